// ===== inc/sacs_pkg.sv
// constants, register map and types of the converter control sequencer
// Functional notes
// - control bits 2:0 select one of eight analog inputs for the converter.
// - start requests during a running conversion are ignored; conversion continues.
// - finished result stays unchanged while the completion flag is one.
// - entering idle or power-down aborts a running conversion.
// - entering idle keeps a completed result and its set completion flag.
// - result bit 1 reads in control bit 7, result bit 0 in bit 6.
// - bit 5 enables the external pin rising edge as a second start source.
// - completion flag bit 4 sets when result is ready; raises masked interrupt.
// - software may clear the completion flag by writing zero, never set it.
// - no conversion starts from any source while the completion flag is set.
// - writing one to bit 3, or an enabled external edge, starts a conversion.
// - software writes of zero to bit 3 are ignored; only hardware clears it.
// - completion set and busy cleared 50 cycles after start (24 short mode; the sequencer has no short mode).
// - result resolved msb first; trial bit kept if input above; four cycles each.
// - upper eight result bits are readable in a separate result-high register.
// - pin must be low one cycle then high one; conversion starts after two synchroniser cycles.
package sacs_pkg;
  localparam int unsigned RES_W  = 10;
  localparam int unsigned CHAN_W = 3;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W  = 6;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL   = 10'h0c5;
  localparam logic [9:0] IDX_RESHI  = 10'h0c6;
  localparam logic [9:0] IDX_ISTAT  = 10'h0c7;
  localparam logic [9:0] IDX_IMASK  = 10'h0c8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RESHI = {IDX_RESHI, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ISTAT = {IDX_ISTAT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IMASK = {IDX_IMASK, 2'b00};
  // control register fields
  localparam int unsigned CTRL_RES1   = 7;
  localparam int unsigned CTRL_RES0   = 6;
  localparam int unsigned CTRL_EXTEN  = 5;
  localparam int unsigned CTRL_DONE   = 4;
  localparam int unsigned CTRL_BUSY   = 3;
  localparam int unsigned CTRL_CH_MSB = 2;
  localparam int unsigned ISTAT_DONE  = 0;
  // reset values
  localparam logic [CHAN_W-1:0] CHAN_RST  = 3'h0;
  localparam logic [RES_W-1:0]  RES_RST   = 10'h000;
  localparam logic [31:0]       DATA_ZERO = 32'h0000_0000;
  // sequencing in machine cycles: one pclk cycle is one machine cycle
  localparam int unsigned INIT_CYC   = 2;
  localparam int unsigned SAMPLE_CYC = 8;
  localparam int unsigned BIT_CYC    = 4;
  localparam int unsigned CONV_CYC   = 50;
  localparam int unsigned SHORT_CYC  = 24;
  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_INIT   = 2'b01,
    S_SAMPLE = 2'b10,
    S_BIT    = 2'b11
  } sacs_state_e;
endpackage

// ===== verilog/sacs_top.sv
// converter control sequencer with apb register access
`timescale 1ns/100ps
module sacs_top import sacs_pkg::*; #(
  parameter int unsigned INIT_N   = INIT_CYC,
  parameter int unsigned SAMPLE_N = SAMPLE_CYC,
  parameter int unsigned BIT_N    = BIT_CYC
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // power modes
  input  wire logic              idle_mode,
  input  wire logic              power_down,
  // external start and analog side
  input  wire logic              ext_trigger_pin,
  input  wire logic              comp_above,
  output logic      [CHAN_W-1:0] chan_sel,
  output logic      [RES_W-1:0]  sar_code,
  // completion
  output logic                   conv_done_flag,
  output logic                   irq
);
  localparam logic [CNT_W-1:0] INIT_LAST   = CNT_W'(INIT_N - 1);
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_N - 1);
  localparam logic [CNT_W-1:0] BIT_LAST    = CNT_W'(BIT_N - 1);
  localparam logic [3:0]       IDX_TOP     = 4'(RES_W - 1);

  // sequencer state and result
  sacs_state_e       state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [3:0]        idx_q;
  logic [RES_W-1:0]  sar_q;
  logic [RES_W-1:0]  sar_kept;
  logic [RES_W-1:0]  res_q;

  // control fields and flags
  logic [CHAN_W-1:0] chan_q;
  logic              ext_en_q;
  logic              done_q;
  logic              busy_q;

  // interrupt status, mask and line
  logic              istat_q;
  logic              istat_d;
  logic              imask_q;
  logic              imask_d;
  logic              irq_q;

  // bus answer registers
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;

  // pin synchronisers
  logic              trig_s1_q;
  logic              trig_s2_q;
  logic              trig_prev_q;
  logic              comp_s1_q;
  logic              comp_s2_q;

  // decode and strobes
  logic              setup;
  logic              access_en;
  logic              wr_ctrl;
  logic              wr_mask;
  logic              rd_istat;
  logic              hit;
  logic              abort;
  logic              sw_start;
  logic              ext_start;
  logic              start_ok;
  logic              fin;
  logic [31:0]       rd_mux;

  // bus phase decode
  assign setup     = psel & ~penable;
  assign access_en = psel & penable & pready_q;
  assign wr_ctrl   = access_en & pwrite & (paddr == ADDR_CTRL);
  assign wr_mask   = access_en & pwrite & (paddr == ADDR_IMASK);
  assign rd_istat  = access_en & ~pwrite & (paddr == ADDR_ISTAT);
  assign hit       = (paddr == ADDR_CTRL) | (paddr == ADDR_RESHI) |
                     (paddr == ADDR_ISTAT) | (paddr == ADDR_IMASK);

  // start sources and abort
  assign abort     = idle_mode | power_down;
  assign sw_start  = wr_ctrl & pwdata[CTRL_BUSY];
  assign ext_start = ext_en_q & trig_s2_q & ~trig_prev_q;
  assign start_ok  = (state_q == S_IDLE) & ~busy_q & ~done_q & ~abort &
                     (sw_start | ext_start);
  assign fin       = (state_q == S_BIT) & (cnt_q == BIT_LAST) &
                     (idx_q == 4'h0) & ~abort;

  // trial bit kept only when the input lies above the trial level
  always_comb begin
    sar_kept        = sar_q;
    sar_kept[idx_q] = comp_s2_q;
  end

  // pin synchronisers and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_q   <= 1'b0;
      trig_s2_q   <= 1'b0;
      trig_prev_q <= 1'b0;
      comp_s1_q   <= 1'b0;
      comp_s2_q   <= 1'b0;
    end else begin
      trig_s1_q   <= ext_trigger_pin;
      trig_s2_q   <= trig_s1_q;
      trig_prev_q <= trig_s2_q;
      comp_s1_q   <= comp_above;
      comp_s2_q   <= comp_s1_q;
    end
  end

  // conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
      idx_q   <= '0;
      sar_q   <= RES_RST;
    end else if (abort) begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          cnt_q <= '0;
          if (start_ok) begin
            state_q <= S_INIT;
          end
        end
        S_INIT: begin
          if (cnt_q == INIT_LAST) begin
            state_q <= S_SAMPLE;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_SAMPLE: begin
          if (cnt_q == SAMPLE_LAST) begin
            state_q <= S_BIT;
            cnt_q   <= '0;
            idx_q   <= IDX_TOP;
            sar_q   <= {1'b1, {(RES_W-1){1'b0}}};
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        S_BIT: begin
          if (cnt_q == BIT_LAST) begin
            cnt_q <= '0;
            if (idx_q == 4'h0) begin
              sar_q   <= sar_kept;
              state_q <= S_IDLE;
            end else begin
              sar_q            <= sar_kept;
              sar_q[idx_q - 1] <= 1'b1;
              idx_q            <= idx_q - 1'b1;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // start/status flag, cleared only by the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (start_ok) begin
      busy_q <= 1'b1;
    end else if (fin | abort) begin
      busy_q <= 1'b0;
    end
  end

  // completion flag: hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (fin) begin
      done_q <= 1'b1;
    end else if (wr_ctrl & ~pwdata[CTRL_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // result latch, loaded only at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= RES_RST;
    end else if (fin & ~done_q) begin
      res_q <= sar_kept;
    end
  end

  // software control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q   <= CHAN_RST;
      ext_en_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        chan_q   <= pwdata[CTRL_CH_MSB:0];
        ext_en_q <= pwdata[CTRL_EXTEN];
      end
    end
  end

  // sticky event status, cleared by reading it; a new event wins
  always_comb begin
    istat_d = istat_q;
    if (fin) begin
      istat_d = 1'b1;
    end else if (rd_istat & prdata_q[ISTAT_DONE]) begin
      istat_d = 1'b0;
    end
  end

  // mask next value, so the interrupt line follows status and mask with no lag
  always_comb begin
    imask_d = imask_q;
    if (wr_mask) begin
      imask_d = pwdata[ISTAT_DONE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= 1'b0;
      imask_q <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      istat_q <= istat_d;
      imask_q <= imask_d;
      irq_q   <= istat_d & imask_d;
    end
  end

  // read data selection
  always_comb begin
    rd_mux = DATA_ZERO;
    unique case (paddr)
      ADDR_CTRL: begin
        rd_mux[CTRL_RES1]     = res_q[1];
        rd_mux[CTRL_RES0]     = res_q[0];
        rd_mux[CTRL_EXTEN]    = ext_en_q;
        rd_mux[CTRL_DONE]     = done_q;
        rd_mux[CTRL_BUSY]     = busy_q;
        rd_mux[CTRL_CH_MSB:0] = chan_q;
      end
      ADDR_RESHI: begin
        rd_mux[RES_W-3:0] = res_q[RES_W-1:2];
      end
      ADDR_ISTAT: begin
        rd_mux[ISTAT_DONE] = istat_q;
      end
      ADDR_IMASK: begin
        rd_mux[ISTAT_DONE] = imask_q;
      end
      default: begin
        rd_mux = DATA_ZERO;
      end
    endcase
  end

  // apb answer: one wait-free access phase after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= DATA_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~hit;
      if (setup & ~pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign chan_sel       = chan_q;
  assign sar_code       = sar_q;
  assign conv_done_flag = done_q;
  assign irq            = irq_q;
endmodule

// ===== test/sacs_top_asserts.sv
// concurrent checks on the converter control sequencer ports
`timescale 1ns/100ps
module sacs_top_asserts import sacs_pkg::*; #(
  parameter int unsigned INIT_N   = INIT_CYC,
  parameter int unsigned SAMPLE_N = SAMPLE_CYC,
  parameter int unsigned BIT_N    = BIT_CYC
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  // converter side
  input wire logic              idle_mode,
  input wire logic              power_down,
  input wire logic [CHAN_W-1:0] chan_sel,
  input wire logic [RES_W-1:0]  sar_code,
  input wire logic              conv_done_flag
);
  localparam int DONE_D = 10 * BIT_N;
  localparam int MSB_D  = BIT_N;
  wire logic acc  = psel && penable && pready;
  wire logic wr_c = acc && pwrite && (paddr == ADDR_CTRL);
  wire logic rd_c = acc && !pwrite && (paddr == ADDR_CTRL);
  wire logic rd_h = acc && !pwrite && (paddr == ADDR_RESHI);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chan_map_a: assert property (wr_c |=> chan_sel == $past(pwdata[2:0]))
    else $error("channel select not taken from write");
  done_hold_a: assert property (conv_done_flag && !(wr_c && !pwdata[4]) |=> conv_done_flag)
    else $error("completion flag dropped");
  result_hold_a: assert property (conv_done_flag && $past(conv_done_flag) |-> $stable(sar_code))
    else $error("result changed while complete");
  done_clear_a: assert property (wr_c && !pwdata[4] && conv_done_flag |=> !conv_done_flag)
    else $error("completion flag not cleared");
  conv_time_a: assert property (disable iff (!presetn || idle_mode || power_down)
    $changed(sar_code) && sar_code == 10'h200 |-> ##DONE_D $rose(conv_done_flag))
    else $error("completion not at expected cycle");
  msb_first_a: assert property (disable iff (!presetn || idle_mode || power_down)
    $changed(sar_code) && sar_code == 10'h200 |-> ##MSB_D sar_code[8:0] == 9'h100)
    else $error("second trial bit wrong");
  lsb_read_a: assert property (rd_c && conv_done_flag |-> prdata[7:6] == sar_code[1:0])
    else $error("low result bits wrong");
  high_read_a: assert property (rd_h && conv_done_flag |-> prdata[7:0] == sar_code[9:2])
    else $error("high result byte wrong");
endmodule

bind sacs_top sacs_top_asserts #(.INIT_N(INIT_N), .SAMPLE_N(SAMPLE_N), .BIT_N(BIT_N))
  u_sacs_top_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .idle_mode(idle_mode), .power_down(power_down), .chan_sel(chan_sel),
  .sar_code(sar_code), .conv_done_flag(conv_done_flag));

// ===== test/sacs_analog_model.sv
// analog inputs, comparator and external start source
`timescale 1ns/100ps
module sacs_analog_model import sacs_pkg::*; (
  // clock and trigger request
  input  wire logic              pclk,
  input  wire logic              trig,
  // converter side
  input  wire logic [CHAN_W-1:0] chan_sel,
  input  wire logic [RES_W-1:0]  sar_code,
  output logic                   comp_above,
  output logic                   ext_trigger_pin
);
  // each channel sits one step above {channel, 7'h55}
  assign comp_above = ({chan_sel, 7'h55} + 10'h001) > sar_code;
  always_ff @(posedge pclk) begin
    ext_trigger_pin <= trig;
  end
endmodule

// ===== test/sacs_top_tb.sv
// testbench of the converter control sequencer
`timescale 1ns/100ps
module sacs_top_tb import sacs_pkg::*;;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic              idle_mode = 0, power_down = 0, trig = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic              pready, pslverr, er, comp_above, ext_trigger_pin, conv_done_flag, irq;
  logic [CHAN_W-1:0] chan_sel;
  logic [RES_W-1:0]  sar_code, e;
  int                err_count = 0, checks_done = 0;
  always #10 pclk = ~pclk;
  sacs_top u_sacs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .idle_mode(idle_mode), .power_down(power_down),
    .ext_trigger_pin(ext_trigger_pin), .comp_above(comp_above), .chan_sel(chan_sel),
    .sar_code(sar_code), .conv_done_flag(conv_done_flag), .irq(irq));
  sacs_analog_model u_sacs_analog_model (.pclk(pclk), .trig(trig), .chan_sel(chan_sel),
    .sar_code(sar_code), .comp_above(comp_above), .ext_trigger_pin(ext_trigger_pin));
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wdone;
    int n;
    n = 0;
    while (conv_done_flag !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk(conv_done_flag, 1);
  endtask
  task automatic pulse;
    repeat (2) @(posedge pclk);
    trig <= 1;
    repeat (2) @(posedge pclk);
    trig <= 0;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, ADDR_CTRL, 0); chk(rd, 0);
    apb(0, 12'h004, 0); chk({rd[30:0], er}, 1);
    apb(1, ADDR_IMASK, 1);
    for (int c = 0; c < 8; c++) begin
      e = {c[2:0], 7'h55};
      apb(1, ADDR_CTRL, {29'h0, c[2:0]} | 32'h08);
      apb(0, ADDR_CTRL, 0); chk(rd[5:0], {3'b001, c[2:0]});
      apb(1, ADDR_CTRL, {29'h0, c[2:0]} | 32'h08);
      wdone;
      @(posedge pclk); chk(irq, 1);
      apb(0, ADDR_CTRL, 0); chk(rd[7:0], {e[1:0], 3'b010, c[2:0]});
      apb(0, ADDR_RESHI, 0); chk(rd, e[9:2]);
      apb(1, ADDR_CTRL, 32'h18); apb(0, ADDR_CTRL, 0); chk(rd[4:3], 2'b10);
      apb(0, ADDR_ISTAT, 0); chk(rd, 1);
      apb(0, ADDR_ISTAT, 0); chk({rd[0], irq}, 0);
      apb(1, ADDR_CTRL, {29'h0, c[2:0]});
    end
    apb(1, ADDR_CTRL, 32'h10); apb(0, ADDR_CTRL, 0); chk(rd[4:3], 0);
    pulse; repeat (60) @(posedge pclk); chk(conv_done_flag, 0);
    e = {3'd5, 7'h55};
    apb(1, ADDR_CTRL, 32'h25); pulse; wdone;
    pulse; idle_mode <= 1; repeat (3) @(posedge pclk); idle_mode <= 0;
    apb(0, ADDR_CTRL, 0); chk(rd[7:0], {e[1:0], 6'h35});
    apb(0, ADDR_ISTAT, 0); chk(rd, 1);
    apb(1, ADDR_CTRL, 32'h05);
    for (int m = 0; m < 2; m++) begin
      apb(1, ADDR_CTRL, 32'h0d); repeat (20) @(posedge pclk);
      apb(1, ADDR_CTRL, 32'h05); apb(0, ADDR_CTRL, 0); chk(rd[4:3], 2'b01);
      idle_mode <= m[0]; power_down <= !m[0]; @(posedge pclk);
      idle_mode <= 0; power_down <= 0;
      apb(0, ADDR_CTRL, 0); chk(rd[4:3], 0);
      repeat (40) @(posedge pclk); chk(conv_done_flag, 0);
    end
    apb(1, ADDR_IMASK, 0); apb(1, ADDR_CTRL, 32'h0d); wdone;
    repeat (2) @(posedge pclk); chk(irq, 0);
    apb(0, ADDR_ISTAT, 0); chk(rd, 1);
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    print_verdict;
  end
endmodule
